/* ppd_regs.vh */
// Purpose: Register map and field layout for the port configuration block
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes:   Some printed offsets are not multiples of four: byte address = 4 * index
`ifndef PPD_REGS_VH
`define PPD_REGS_VH

// ****************************************************************
// Register indices and byte addresses
// ****************************************************************
`define PPD_IDX_PE_DIR        12'h003
`define PPD_IDX_DRIVE         12'h00D
`define PPD_IDX_PA_IN         12'h120
`define PPD_IDX_PE_IN         12'h121
`define PPD_IDX_PULL          12'h004
`define PPD_AW                12
`define PPD_ADDR_LSB          2

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define PPD_PE_DIR_MASK       8'h03
`define PPD_PULL_DBG_BIT      6
`define PPD_PULL_PE_BIT       1
`define PPD_PULL_MASK         8'h42
`define PPD_PULL_RESET        8'h42
`define PPD_DRV_PD_BIT        3
`define PPD_DRV_PC_BIT        2
`define PPD_DRV_MASK          8'h0C
`define PPD_DRV_RESET         8'h00
`define PPD_PE_DIR_RESET      8'h00
`define PPD_PE_DIR_W          2
`define PPD_PE_DIR_RST        2'h0
`define PPD_PULL_DBG_RST      1'b1
`define PPD_PULL_PE_RST       1'b1
`define PPD_DRV_RST           1'b0
`define PPD_PA_W              8
`define PPD_PE_W              2
`define PPD_RESP_OKAY         2'h0
`define PPD_RESP_SLVERR       2'h2

`endif

/* ppd_port_cfg.v */
// Purpose: Port E direction, pull devices, drive strength and pin input registers
// Assumes: Pins synchronous-capable via two-stage synchroniser; AXI4-Lite slave
// Notes:   Unmapped addresses answer SLVERR and read zero
`timescale 1ns/100ps
`include "ppd_regs.vh"

module ppd_port_cfg
(
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_resetn,
  // AXI4-Lite write address and data
  input  wire [31:0] i_awaddr,
  input  wire        i_awvalid,
  output wire        o_awready,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  input  wire        i_wvalid,
  output wire        o_wready,
  // AXI4-Lite write response
  output reg  [1:0]  o_bresp,
  output reg         o_bvalid,
  input  wire        i_bready,
  // AXI4-Lite read
  input  wire [31:0] i_araddr,
  input  wire        i_arvalid,
  output wire        o_arready,
  output reg  [31:0] o_rdata,
  output reg  [1:0]  o_rresp,
  output reg         o_rvalid,
  input  wire        i_rready,
  // Pins and oscillator
  input  wire [7:0]  i_port_a_pins,
  input  wire [1:0]  i_port_e_pins,
  input  wire [1:0]  i_port_e_gpio_out,
  input  wire        i_osc_enable,
  input  wire        i_debug_pin_drive,
  output wire [1:0]  o_port_e_oe,
  output wire [1:0]  o_port_e_to_osc,
  output wire [1:0]  o_port_e_pulldown,
  output wire        o_debug_pin_pullup,
  output wire        o_port_d_reduced_drive,
  output wire        o_die_link_clock_reduced
);

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  wire [`PPD_PE_DIR_W-1:0] port_e_direction;
  wire        debug_pin_pullup_enable;
  wire        port_e_pulldown_enable;
  wire        port_d_reduced_drive;
  wire        port_c_reduced_drive;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  wire [`PPD_PA_W-1:0] pin_sync_a;
  wire [`PPD_PE_W-1:0] pin_sync_e;

  ppd_sync2 #(.WIDTH(`PPD_PA_W)) u_sync_a
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_async  (i_port_a_pins),
    .o_sync   (pin_sync_a)
  );

  ppd_sync2 #(.WIDTH(`PPD_PE_W)) u_sync_e
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_async  (i_port_e_pins),
    .o_sync   (pin_sync_e)
  );

  // ****************************************************************
  // Pin control outputs
  // ****************************************************************
  assign o_port_e_to_osc   = {2{i_osc_enable}};
  assign o_port_e_oe       = i_osc_enable ? 2'h0 : port_e_direction;
  assign o_port_e_pulldown = (i_osc_enable || !port_e_pulldown_enable) ? 2'h0 :
                             ~port_e_direction;
  assign o_debug_pin_pullup     = debug_pin_pullup_enable & ~i_debug_pin_drive;
  assign o_port_d_reduced_drive   = port_d_reduced_drive;
  assign o_die_link_clock_reduced = port_c_reduced_drive;

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  reg         aw_held;
  reg         w_held;
  reg  [`PPD_AW-1:0] aw_idx;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  wire        aw_take = i_awvalid && o_awready;
  wire        w_take  = i_wvalid && o_wready;
  wire        do_write = aw_held && w_held && !o_bvalid;
  wire        wr_hit;

  assign o_awready = !aw_held && !o_bvalid;
  assign o_wready  = !w_held && !o_bvalid;
  assign wr_hit = (aw_idx == `PPD_IDX_PE_DIR) || (aw_idx == `PPD_IDX_PULL) ||
                  (aw_idx == `PPD_IDX_DRIVE)  || (aw_idx == `PPD_IDX_PA_IN) ||
                  (aw_idx == `PPD_IDX_PE_IN);

  // ****************************************************************
  // Configuration fields
  // ****************************************************************
  wire        sel_pe_dir = (aw_idx == `PPD_IDX_PE_DIR);
  wire        sel_pull   = (aw_idx == `PPD_IDX_PULL);
  wire        sel_drive  = (aw_idx == `PPD_IDX_DRIVE);
  // Input registers own no field, so writes to them fall away
  wire        reg_we     = do_write && w_strb[0];

  ppd_cfg_field #(.WIDTH(`PPD_PE_DIR_W), .RESET(`PPD_PE_DIR_RST)) u_pe_dir
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_we     (reg_we && sel_pe_dir),
    .i_d      (w_data[`PPD_PE_DIR_W-1:0]),
    .o_q      (port_e_direction)
  );

  ppd_cfg_field #(.WIDTH(1), .RESET(`PPD_PULL_DBG_RST)) u_dbg_pullup
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_we     (reg_we && sel_pull),
    .i_d      (w_data[`PPD_PULL_DBG_BIT]),
    .o_q      (debug_pin_pullup_enable)
  );

  ppd_cfg_field #(.WIDTH(1), .RESET(`PPD_PULL_PE_RST)) u_pe_pulldown
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_we     (reg_we && sel_pull),
    .i_d      (w_data[`PPD_PULL_PE_BIT]),
    .o_q      (port_e_pulldown_enable)
  );

  ppd_cfg_field #(.WIDTH(1), .RESET(`PPD_DRV_RST)) u_pd_drive
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_we     (reg_we && sel_drive),
    .i_d      (w_data[`PPD_DRV_PD_BIT]),
    .o_q      (port_d_reduced_drive)
  );

  ppd_cfg_field #(.WIDTH(1), .RESET(`PPD_DRV_RST)) u_pc_drive
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_we     (reg_we && sel_drive),
    .i_d      (w_data[`PPD_DRV_PC_BIT]),
    .o_q      (port_c_reduced_drive)
  );

  always @(posedge i_clk or negedge i_resetn)
    if (!i_resetn)
    begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      aw_idx   <= {`PPD_AW{1'b0}};
      w_data   <= 32'h00000000;
      w_strb   <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp  <= `PPD_RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held <= 1'b1;
        aw_idx  <= i_awaddr[`PPD_AW+`PPD_ADDR_LSB-1:`PPD_ADDR_LSB];
      end
      if (w_take)
      begin
        w_held <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (do_write)
      begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp  <= wr_hit ? `PPD_RESP_OKAY : `PPD_RESP_SLVERR;
      end
      else if (o_bvalid && i_bready)
        o_bvalid <= 1'b0;
    end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  reg  [31:0] next_rdata;
  reg  [1:0]  next_rresp;
  wire [`PPD_AW-1:0] ar_idx = i_araddr[`PPD_AW+`PPD_ADDR_LSB-1:`PPD_ADDR_LSB];

  assign o_arready = !o_rvalid;

  always @*
  begin
    next_rdata = 32'h00000000;
    next_rresp = `PPD_RESP_OKAY;
    case (ar_idx)
      `PPD_IDX_PE_DIR:
        next_rdata[`PPD_PE_DIR_W-1:0] = port_e_direction;
      `PPD_IDX_PULL:
      begin
        next_rdata[`PPD_PULL_DBG_BIT] = debug_pin_pullup_enable;
        next_rdata[`PPD_PULL_PE_BIT]  = port_e_pulldown_enable;
      end
      `PPD_IDX_DRIVE:
      begin
        next_rdata[`PPD_DRV_PD_BIT] = port_d_reduced_drive;
        next_rdata[`PPD_DRV_PC_BIT] = port_c_reduced_drive;
      end
      `PPD_IDX_PA_IN:
        next_rdata[`PPD_PA_W-1:0] = pin_sync_a;
      `PPD_IDX_PE_IN:
        next_rdata[`PPD_PE_W-1:0] = pin_sync_e;
      default:
        next_rresp = `PPD_RESP_SLVERR;
    endcase
  end

  always @(posedge i_clk or negedge i_resetn)
    if (!i_resetn)
    begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h00000000;
      o_rresp  <= `PPD_RESP_OKAY;
    end
    else if (i_arvalid && o_arready)
    begin
      o_rvalid <= 1'b1;
      o_rdata  <= next_rdata;
      o_rresp  <= next_rresp;
    end
    else if (o_rvalid && i_rready)
      o_rvalid <= 1'b0;

endmodule

// ****************************************************************
// Two-stage synchroniser for pin levels
// ****************************************************************
module ppd_sync2
#(
  parameter WIDTH = 1
)
(
  // Clock and reset
  input  wire             i_clk,
  input  wire             i_resetn,
  // Levels
  input  wire [WIDTH-1:0] i_async,
  output reg  [WIDTH-1:0] o_sync
);

  reg  [WIDTH-1:0] meta;

  always @(posedge i_clk or negedge i_resetn)
    if (!i_resetn)
    begin
      meta   <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end
    else
    begin
      // Only the second stage is read outside
      meta   <= i_async;
      o_sync <= meta;
    end

endmodule

// ****************************************************************
// Writable configuration field with reset value
// ****************************************************************
module ppd_cfg_field
#(
  parameter             WIDTH = 1,
  parameter [WIDTH-1:0] RESET = {WIDTH{1'b0}}
)
(
  // Clock and reset
  input  wire             i_clk,
  input  wire             i_resetn,
  // Write port
  input  wire             i_we,
  input  wire [WIDTH-1:0] i_d,
  // Stored value
  output reg  [WIDTH-1:0] o_q
);

  always @(posedge i_clk or negedge i_resetn)
    if (!i_resetn)
      o_q <= RESET;
    else if (i_we)
      o_q <= i_d;

endmodule

/* ppd_port_cfg_monitor.sv */
// Purpose: Port checks for the port configuration block
// Assumes: Single clock, reset active low
// Notes:   Bound in the bench top file
`timescale 1ns/100ps
module ppd_port_cfg_monitor
(
  // Clock, reset and bus
  input wire        i_clk,
  input wire        i_resetn,
  input wire        i_arvalid,
  input wire        o_arready,
  input wire        o_rvalid,
  input wire [31:0] o_rdata,
  // Pin side
  input wire        i_osc_enable,
  input wire        i_debug_pin_drive,
  input wire [1:0]  o_port_e_oe,
  input wire [1:0]  o_port_e_to_osc,
  input wire [1:0]  o_port_e_pulldown,
  input wire        o_debug_pin_pullup,
  input wire        o_port_d_reduced_drive,
  input wire        o_die_link_clock_reduced
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_ar_take;
    i_arvalid && o_arready;
  endsequence
  a_osc_no_oe: assert property (i_osc_enable |-> o_port_e_oe == 2'h0)
    else $error("oe while oscillator owns pins");
  a_osc_route: assert property (i_osc_enable |-> o_port_e_to_osc == 2'h3)
    else $error("pins not routed to oscillator");
  a_osc_no_pd: assert property (i_osc_enable |-> o_port_e_pulldown == 2'h0)
    else $error("pulldown on in oscillator mode");
  a_pd_inputs: assert property ((o_port_e_oe & o_port_e_pulldown) == 2'h0)
    else $error("pulldown on an output pin");
  a_dbg_pu_off: assert property (i_debug_pin_drive |-> !o_debug_pin_pullup)
    else $error("pullup on driven debug pin");
  a_read_answer: assert property (s_ar_take |=> o_rvalid)
    else $error("read not answered next cycle");
  a_rdata_hi: assert property (s_ar_take ##1 o_rvalid |-> o_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_reset_vals: assert property ($rose(i_resetn) |-> !o_port_d_reduced_drive
    && !o_die_link_clock_reduced && (o_debug_pin_pullup || i_debug_pin_drive))
    else $error("wrong state after reset");
endmodule

/* ppd_pin_model.sv */
// Purpose: External pins seen by the port block
// Assumes: Bench levels are weak, pulldown wins
// Notes:   Device drive wins over both
`timescale 1ns/100ps
module ppd_pin_model
(
  // Bench levels
  input  wire [7:0] i_lvl_a,
  input  wire [1:0] i_lvl_e,
  // Device side
  input  wire [1:0] i_oe,
  input  wire [1:0] i_gpio,
  input  wire [1:0] i_pulldown,
  // Pins
  output wire [7:0] o_pins_a,
  output wire [1:0] o_pins_e
);
  assign o_pins_a = i_lvl_a;
  assign o_pins_e = (i_oe & i_gpio) | (~i_oe & ~i_pulldown & i_lvl_e);
endmodule

/* ppd_port_cfg_tb_top.sv */
// Purpose: Self-checking bench for the port configuration block
// Assumes: AXI4-Lite master, 50 MHz clock
// Notes:   Each scenario is its own task
`timescale 1ns/100ps
`include "ppd_regs.vh"
module ppd_port_cfg_tb_top;
  reg         i_clk = 0, i_resetn = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
  reg         i_arvalid = 0, i_rready = 0, i_osc_enable = 0, i_debug_pin_drive = 0;
  reg  [31:0] i_awaddr = 0, i_wdata = 0, i_araddr = 0;
  reg  [3:0]  i_wstrb = 4'hF;
  reg  [7:0]  lvl_a = 8'h00;
  reg  [1:0]  lvl_e = 2'h0, i_port_e_gpio_out = 2'h0;
  wire        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_debug_pin_pullup;
  wire        o_port_d_reduced_drive, o_die_link_clock_reduced;
  wire [1:0]  o_bresp, o_rresp, o_port_e_oe, o_port_e_to_osc, o_port_e_pulldown, i_port_e_pins;
  wire [31:0] o_rdata;
  wire [7:0]  i_port_a_pins;
  reg  [31:0] d;
  reg  [1:0]  r;
  int         num_errors = 0, n_checks = 0;
  ppd_port_cfg dut (.i_clk, .i_resetn, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
    .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_port_a_pins, .i_port_e_pins,
    .i_port_e_gpio_out, .i_osc_enable, .i_debug_pin_drive, .o_port_e_oe, .o_port_e_to_osc,
    .o_port_e_pulldown, .o_debug_pin_pullup, .o_port_d_reduced_drive, .o_die_link_clock_reduced);
  ppd_pin_model pins (.i_lvl_a(lvl_a), .i_lvl_e(lvl_e), .i_oe(o_port_e_oe),
    .i_gpio(i_port_e_gpio_out), .i_pulldown(o_port_e_pulldown),
    .o_pins_a(i_port_a_pins), .o_pins_e(i_port_e_pins));
  initial forever #10 i_clk = ~i_clk;
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input [31:0] s, input [31:0] e, input string nm);
    n_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task tmo(input bit done);
    if (!done)
    begin
      num_errors++;
      give_verdict;
    end
  endtask
  task wr(input [11:0] ix, input [31:0] v);
    int n;
    reg a, w, b;
    b = 0;
    @(posedge i_clk);
    i_awaddr <= {18'h0, ix, 2'h0}; i_wdata <= v;
    i_awvalid <= 1; i_wvalid <= 1; i_bready <= 1;
    for (n = 0; n < 50 && !b; n++)
    begin
      @(negedge i_clk); a = o_awready; w = o_wready; b = o_bvalid; r = o_bresp;
      @(posedge i_clk); if (a) i_awvalid <= 0; if (w) i_wvalid <= 0; if (b) i_bready <= 0;
    end
    tmo(b);
  endtask
  task rd(input [11:0] ix);
    int n;
    reg a, v;
    v = 0;
    @(posedge i_clk);
    i_araddr <= {18'h0, ix, 2'h0}; i_arvalid <= 1; i_rready <= 1;
    for (n = 0; n < 50 && !v; n++)
    begin
      @(negedge i_clk); a = o_arready; v = o_rvalid; d = o_rdata; r = o_rresp;
      @(posedge i_clk); if (a) i_arvalid <= 0; if (v) i_rready <= 0;
    end
    tmo(v);
  endtask
  task t_reset;
    rd(`PPD_IDX_PE_DIR); chk(d, 32'h0, "dir");
    rd(`PPD_IDX_PULL); chk(d, 32'h42, "pull");
    rd(`PPD_IDX_DRIVE); chk(d, 32'h0, "drive");
    chk(r, 2'h0, "rresp");
    chk(o_debug_pin_pullup, 1, "pullup");
    $display("t_reset done");
  endtask
  task t_dir;
    wr(`PPD_IDX_PE_DIR, 32'hFF); rd(`PPD_IDX_PE_DIR); chk(d, 32'h3, "dir");
    chk(o_port_e_oe, 2'h3, "oe"); chk(o_port_e_pulldown, 2'h0, "pd out");
    i_port_e_gpio_out <= 2'h1; repeat (3) @(posedge i_clk);
    rd(`PPD_IDX_PE_IN); chk(d, 32'h1, "pe out");
    wr(`PPD_IDX_PE_DIR, 32'h0); chk(o_port_e_pulldown, 2'h3, "pd in");
    i_osc_enable <= 1; i_debug_pin_drive <= 1;
    wr(`PPD_IDX_PE_DIR, 32'h3); chk(o_port_e_oe, 2'h0, "oe osc");
    chk(r, 2'h0, "bresp");
    chk(o_port_e_to_osc, 2'h3, "to osc");
    rd(`PPD_IDX_PE_DIR); chk(d, 32'h3, "dir osc");
    wr(`PPD_IDX_PE_DIR, 32'h0); chk(o_port_e_pulldown, 2'h0, "pd osc");
    rd(`PPD_IDX_PULL); chk(d, 32'h42, "pull osc");
    chk(o_debug_pin_pullup, 0, "pullup drv");
    i_osc_enable <= 0; i_debug_pin_drive <= 0;
    $display("t_dir done");
  endtask
  task t_drive;
    wr(`PPD_IDX_DRIVE, 32'hFF); rd(`PPD_IDX_DRIVE); chk(d, 32'hC, "drive");
    chk(o_port_d_reduced_drive, 1, "pd drv");
    wr(`PPD_IDX_DRIVE, 32'h4); chk(o_port_d_reduced_drive, 0, "pd full");
    chk(o_die_link_clock_reduced, 1, "clk drv");
    wr(12'h005, 32'h1); chk(r, 2'h2, "unmapped");
    rd(12'h005); chk(d, 32'h0, "unm rd");
    chk(r, 2'h2, "unm rresp");
    $display("t_drive done");
  endtask
  task t_pins;
    lvl_a <= 8'hA5; lvl_e <= 2'h2;
    repeat (3) @(posedge i_clk);
    rd(`PPD_IDX_PE_IN); chk(d, 32'h0, "pe pd");
    wr(`PPD_IDX_PULL, 32'h40); repeat (3) @(posedge i_clk);
    rd(`PPD_IDX_PE_IN); chk(d, 32'h2, "pe in");
    wr(`PPD_IDX_PA_IN, 32'h0); rd(`PPD_IDX_PA_IN); chk(d, 32'hA5, "pa wr");
    i_resetn <= 0; repeat (2) @(posedge i_clk); i_resetn <= 1;
    repeat (3) @(posedge i_clk);
    rd(`PPD_IDX_PA_IN); chk(d, 32'hA5, "pa rst");
    $display("t_pins done");
  endtask
  initial
  begin
    repeat (10) @(posedge i_clk);
    i_resetn <= 1;
    t_reset; t_dir; t_drive; t_pins;
    give_verdict;
  end
endmodule
bind ppd_port_cfg ppd_port_cfg_monitor mon (.i_clk, .i_resetn, .i_arvalid, .o_arready,
  .o_rvalid, .o_rdata, .i_osc_enable, .i_debug_pin_drive, .o_port_e_oe, .o_port_e_to_osc,
  .o_port_e_pulldown, .o_debug_pin_pullup, .o_port_d_reduced_drive, .o_die_link_clock_reduced);
